// ==== verilog/hfi_regs.sv ====
// host flag and init-block address registers behind an ahb-lite slave
// assumes one slave on the bus, zero wait states, single word transfers
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - commands available starts fetch when list valid and running
// - device sets responses available per response
// - writing one clears responses available
// - responses available raises interrupt if enabled
// - abort with reset write skips self-test
// - self-test result code into low address
// - stop reason code into low address
// - failing self-test code into high address
// - stop while running zeroes high address
// - reset bit clears after init completes
// - host sets running, clears it only with a reset write
// - device clears running when it cannot continue
module hfi_regs
  import hfi_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic init_start,
  output logic init_skip,
  output logic init_busy,
  input wire hfi_test_s test_res,
  input wire logic resp_added,
  input wire hfi_halt_s halt,
  input wire logic list_end,
  output logic list_valid,
  output logic fetch_req,
  input wire logic fetch_ack,
  output logic running,
  output logic int_enable,
  output logic irq
);

  // the index decode needs bits [5:2] at least
  if (ADDR_W < 6)
  begin : g_chk
    $error("hfi_regs: ADDR_W too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // bus address phase capture

  logic acc;         // transfer accepted this cycle
  logic [7:0] idx;   // word index of the address phase
  logic wr_q;        // write data phase pending
  logic [7:0] widx_q;  // index held for the write data phase
  logic [31:0] rdat_d;
  logic [31:0] rdat_q;

  assign acc = hsel & hready & htrans[1];
  assign idx = 8'(haddr[ADDR_W-1:2]);

  // write is carried into the data phase where hwdata stands
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      widx_q <= 8'h00;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= acc & hwrite;
      widx_q <= idx;
      // read data is fetched at the address phase so it comes from a flop
      if (acc & ~hwrite)
        rdat_q <= rdat_d;
    end
  end

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdat_q;

  ////////////////////////////////////////////////////////////////////////
  // data phase write strobes

  logic wr_flag;
  logic wr_adrl;
  logic wr_adrh;
  logic wr_ists;
  logic wr_imsk;

  assign wr_flag = wr_q & (widx_q == FLAG_IDX);
  assign wr_adrl = wr_q & (widx_q == ADRL_IDX);
  assign wr_adrh = wr_q & (widx_q == ADRH_IDX);
  assign wr_ists = wr_q & (widx_q == ISTS_IDX);
  assign wr_imsk = wr_q & (widx_q == IMSK_IDX);

  ////////////////////////////////////////////////////////////////////////
  // init sequencer and flag control state

  hfi_init_e st_q;
  logic start_q;     // one-cycle init start towards self-test
  logic skip_q;      // self-test skipped for this init
  logic run_q;
  logic inten_q;
  logic lvalid_q;
  logic cavail_q;
  logic ravail_q;
  logic [15:0] adrl_q;
  logic [15:0] adrh_q;

  logic host_reset;  // host asks for a new init
  logic host_run;    // host sets running
  logic test_fin;    // self-test finished while testing
  logic stop_ev;     // engine stop while running
  logic fetch_done;
  logic [15:0] stop_code;

  assign host_reset = wr_flag & hwdata[B_RESET] & (st_q == ST_IDLE);
  assign host_run = wr_flag & hwdata[B_RUN] & (st_q == ST_IDLE);
  assign test_fin = test_res.done & (st_q == ST_TEST);
  assign stop_ev = halt.stop & run_q;
  assign fetch_done = fetch_req & fetch_ack;
  assign stop_code = (halt.reason == RS_BADINIT) ? CODE_BADINIT :
                     (halt.reason == RS_XFER) ? CODE_XFER : CODE_INTERR;

  // init sequence: reset bit stands until the self-test reports done
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= ST_TEST;
      start_q <= 1'b1;
      skip_q <= 1'b0;
    end
    else
    begin
      start_q <= host_reset;
      if (test_fin)
        st_q <= ST_IDLE;
      else if (host_reset)
        st_q <= ST_TEST;
      if (host_reset)
        skip_q <= hwdata[B_ABORT];
      else if (test_fin)
        skip_q <= 1'b0;
    end
  end

  // running and interrupt enable; the host clears running only with a reset write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_q <= 1'b0;
      inten_q <= 1'b0;
    end
    else
    begin
      if (stop_ev | host_reset)
        run_q <= 1'b0;
      else if (host_run)
        run_q <= 1'b1;
      if (host_reset)
        inten_q <= 1'b0;
      else if (wr_flag)
        inten_q <= hwdata[B_INTEN];
    end
  end

  // list valid and commands available: set only, zeros are ignored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lvalid_q <= 1'b0;
      cavail_q <= 1'b0;
    end
    else
    begin
      // host set, device clear; set wins
      if (wr_flag & hwdata[B_LVALID])
        lvalid_q <= 1'b1;
      else if (list_end | host_reset)
        lvalid_q <= 1'b0;
      if (wr_flag & hwdata[B_CAVAIL])
        cavail_q <= 1'b1;
      else if (fetch_done | host_reset)
        cavail_q <= 1'b0;
    end
  end

  assign fetch_req = cavail_q & lvalid_q & run_q;

  // responses available: device sets, host writes one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ravail_q <= 1'b0;
    else if (resp_added)
      ravail_q <= 1'b1;
    else if (wr_flag & hwdata[B_RAVAIL])
      ravail_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // address registers, doubling as result channels

  logic [15:0] test_code;
  assign test_code = skip_q ? CODE_SKIP : (test_res.pass ? CODE_PASS : CODE_FAIL);

  // device reports win over a host write in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      adrl_q <= ADR_RST;
      adrh_q <= ADR_RST;
    end
    else
    begin
      if (test_fin)
        adrl_q <= test_code;
      else if (stop_ev)
        adrl_q <= stop_code;
      else if (wr_adrl)
        adrl_q <= hwdata[15:0];
      if (test_fin & ~skip_q & ~test_res.pass)
        adrh_q <= test_res.code;
      else if (stop_ev)
        adrh_q <= ADR_RST;
      else if (wr_adrh)
        adrh_q <= hwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  logic [I_W-1:0] ists_q;
  logic [I_W-1:0] imsk_q;
  logic [I_W-1:0] iset;

  // responses and stops only count as interrupt events while enabled; init done always counts
  assign iset = {test_fin, stop_ev & inten_q, resp_added & inten_q};

  // sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ists_q <= IMSK_RST;
      imsk_q <= IMSK_RST;
    end
    else
    begin
      ists_q <= iset | (ists_q & ~({I_W{wr_ists}} & hwdata[I_W-1:0]));
      if (wr_imsk)
        imsk_q <= hwdata[I_W-1:0];
    end
  end

  assign irq = |(ists_q & imsk_q);

  ////////////////////////////////////////////////////////////////////////
  // read mux; set-only bits always read as zero

  logic [15:0] flag_rd;
  assign flag_rd = {1'b0, ravail_q, 2'b00, 1'b0, run_q, st_q == ST_TEST, inten_q, DEV_TYPE};

  assign rdat_d = (idx == FLAG_IDX) ? {16'h0000, flag_rd} :
                  (idx == ADRL_IDX) ? {16'h0000, adrl_q} :
                  (idx == ADRH_IDX) ? {16'h0000, adrh_q} :
                  (idx == ISTS_IDX) ? {29'h0000_0000, ists_q} :
                  (idx == IMSK_IDX) ? {29'h0000_0000, imsk_q} : 32'h0000_0000;

  assign init_start = start_q;
  assign init_skip = skip_q;
  assign init_busy = (st_q == ST_TEST);
  assign list_valid = lvalid_q;
  assign running = run_q;
  assign int_enable = inten_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic rd_flag_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_flag_q <= 1'b0;
    else
      rd_flag_q <= acc & ~hwrite & (idx == FLAG_IDX);
  end

  property p_setonly_read;
    @(posedge hclk) disable iff (!hresetn)
    rd_flag_q |-> (hrdata[15] == 1'b0) && (hrdata[13:12] == 2'b00);
  endproperty
  a_setonly_read: assert property (p_setonly_read) else $error("set-only bit read nonzero");

  property p_fetch;
    @(posedge hclk) disable iff (!hresetn)
    wr_flag && hwdata[B_CAVAIL] && lvalid_q && run_q && !stop_ev &&
      !host_reset && !list_end |=> fetch_req;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch after commands available");

  property p_resp_set;
    @(posedge hclk) disable iff (!hresetn)
    resp_added |=> flag_rd[B_RAVAIL];
  endproperty
  a_resp_set: assert property (p_resp_set) else $error("responses flag not set");

  property p_resp_clr;
    @(posedge hclk) disable iff (!hresetn)
    wr_flag && hwdata[B_RAVAIL] && !resp_added |=> !ravail_q;
  endproperty
  a_resp_clr: assert property (p_resp_clr) else $error("responses flag not cleared");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    resp_added && inten_q && imsk_q[I_RESP] && !wr_imsk |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt on response");

  property p_skip;
    @(posedge hclk) disable iff (!hresetn)
    test_fin && skip_q |=> adrl_q == CODE_SKIP && !init_busy;
  endproperty
  a_skip: assert property (p_skip) else $error("skip code missing");

  property p_pass;
    @(posedge hclk) disable iff (!hresetn)
    test_fin && !skip_q && test_res.pass |=> adrl_q == CODE_PASS;
  endproperty
  a_pass: assert property (p_pass) else $error("pass code missing");

  property p_stop;
    @(posedge hclk) disable iff (!hresetn)
    stop_ev && !test_fin |=> adrh_q == 16'h0000 && !run_q && adrl_q == $past(stop_code);
  endproperty
  a_stop: assert property (p_stop) else $error("stop report wrong");

  property p_hold_reset;
    @(posedge hclk) disable iff (!hresetn)
    init_busy && !test_res.done |=> init_busy;
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("reset bit dropped early");

  property p_run;
    @(posedge hclk) disable iff (!hresetn)
    host_run && !stop_ev && !host_reset |=> running;
  endproperty
  a_run: assert property (p_run) else $error("running not set");

  property p_zero_wr;
    @(posedge hclk) disable iff (!hresetn)
    wr_flag && !hwdata[B_LVALID] && !lvalid_q |=> !lvalid_q;
  endproperty
  a_zero_wr: assert property (p_zero_wr) else $error("zero write set list valid");

  c_init: cover property (@(posedge hclk) disable iff (!hresetn) test_fin ##1 host_run);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) resp_added ##1 irq);
  c_stop: cover property (@(posedge hclk) disable iff (!hresetn) stop_ev);

endmodule

// ==== verilog/hfi_pkg.sv ====
// package for the host flag and init-block address register bank
// assumes a 32-bit ahb-lite bus and a separate self-test / list engine
package hfi_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] FLAG_IDX = 8'h02;
  localparam logic [7:0] ADRL_IDX = 8'h04;
  localparam logic [7:0] ADRH_IDX = 8'h06;
  localparam logic [7:0] ISTS_IDX = 8'h08;
  localparam logic [7:0] IMSK_IDX = 8'h09;
  // flag register bit positions
  localparam int B_INTEN = 8;
  localparam int B_RESET = 9;
  localparam int B_RUN = 10;
  localparam int B_LVALID = 12;
  localparam int B_CAVAIL = 13;
  localparam int B_RAVAIL = 14;
  localparam int B_ABORT = 15;
  // device type byte, returned in the flag low byte
  localparam logic [7:0] DEV_TYPE = 8'h01;
  // self-test result codes left in the low address register
  localparam logic [15:0] CODE_PASS = 16'hAAAA;
  localparam logic [15:0] CODE_FAIL = 16'h5555;
  localparam logic [15:0] CODE_SKIP = 16'h55AA;
  // stop reason codes left in the low address register
  localparam logic [15:0] CODE_BADINIT = 16'h0001;
  localparam logic [15:0] CODE_INTERR = 16'h0002;
  localparam logic [15:0] CODE_XFER = 16'h0003;
  // interrupt status / mask bit positions
  localparam int I_RESP = 0;
  localparam int I_STOP = 1;
  localparam int I_INIT = 2;
  localparam int I_W = 3;
  // reset values
  localparam logic [15:0] ADR_RST = 16'h0000;
  localparam logic [I_W-1:0] IMSK_RST = 3'h0;
  // init sequencer states
  typedef enum logic {ST_TEST, ST_IDLE} hfi_init_e;
  // stop reason from the list engine
  typedef enum logic [1:0] {RS_BADINIT, RS_INTERR, RS_XFER, RS_OTHER} hfi_reason_e;
  // self-test completion report
  typedef struct packed {
    logic done;
    logic pass;
    logic [15:0] code;
  } hfi_test_s;
  // list engine stop report
  typedef struct packed {
    logic stop;
    hfi_reason_e reason;
  } hfi_halt_s;
endpackage

// ==== tb/hfi_regs_tb_top.sv ====
// self-checking bench for the host flag and init-block address registers
// assumes one ahb-lite slave, so hready follows hreadyout
`timescale 1ns/1ps

module hfi_regs_tb_top
  import hfi_pkg::*;
;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hready;
  hfi_test_s test_res;
  hfi_halt_s halt;
  logic resp_added;
  logic list_end;
  logic fetch_ack;
  logic list_valid;
  logic fetch_req;
  logic running;
  logic init_skip;
  logic init_busy;
  logic irq;
  int failures;
  int num_checks;
  logic hresp;
  logic init_start;
  logic int_enable;
  // byte addresses, four times the register index
  localparam logic [7:0] A_FLAG = 8'h08;
  localparam logic [7:0] A_ADRL = 8'h10;
  localparam logic [7:0] A_ADRH = 8'h18;
  localparam logic [7:0] A_STS = 8'h20;
  localparam logic [7:0] A_MSK = 8'h24;
  // stop reason 3 reports as an internal error
  logic [15:0] stop_code [4] = '{CODE_BADINIT, CODE_INTERR, CODE_XFER, CODE_INTERR};

  assign hready = hreadyout;

  hfi_regs #(.ADDR_W(8)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .init_start(init_start),
    .init_skip(init_skip), .init_busy(init_busy), .test_res(test_res),
    .resp_added(resp_added), .halt(halt), .list_end(list_end),
    .list_valid(list_valid), .fetch_req(fetch_req), .fetch_ack(fetch_ack),
    .running(running), .int_enable(int_enable), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, 5 ns period
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counts and verdict; the only place the run ends
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // bounded wait for hready high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      failures++;
      $display("CHECK FAILED hready expected 1 seen %b", hready);
      final_report();
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    // step off the edge so callers see the registers after the write lands
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(n, e, x);
  endtask

  // one-cycle engine event; 0 resp, 1 fetch ack, 2 list end, 3 halt,
  // 4 test pass, 5 test fail with code v
  task automatic ev(input int k, input logic [15:0] v);
    @(posedge hclk);
    case (k)
      0: resp_added <= 1'b1;
      1: fetch_ack <= 1'b1;
      2: list_end <= 1'b1;
      3: halt <= '{stop: 1'b1, reason: hfi_reason_e'(v[1:0])};
      default: test_res <= '{done: 1'b1, pass: (k == 4), code: v};
    endcase
    @(posedge hclk);
    resp_added <= 1'b0;
    fetch_ack <= 1'b0;
    list_end <= 1'b0;
    halt <= '0;
    test_res <= '0;
    @(posedge hclk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    failures = 0;
    num_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    test_res = '0;
    halt = '0;
    resp_added = 1'b0;
    list_end = 1'b0;
    fetch_ack = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // busy after reset, then self-test passes
    rd(A_FLAG, 32'h0000_0201, "flag after reset");
    chk("init start after reset", 32'h0, {31'h0, init_start});
    wr(A_FLAG, 32'h0000_0400);
    chk("running while busy", 32'h0, {31'h0, running});
    ev(4, 16'h0000);
    chk("busy after test", 32'h0, {31'h0, init_busy});
    rd(A_ADRL, {16'h0000, CODE_PASS}, "pass code");
    rd(8'h2C, 32'h0000_0000, "unmapped");
    // host loads the init block address
    wr(A_ADRL, 32'h0000_1234);
    wr(A_ADRH, 32'h0000_003F);
    rd(A_ADRL, 32'h0000_1234, "addr low");
    rd(A_ADRH, 32'h0000_003F, "addr high");
    // zero to set-only bits leaves state alone
    wr(A_FLAG, 32'h0000_0100);
    chk("list valid zero write", 32'h0, {31'h0, list_valid});
    chk("int enable set", 32'h1, {31'h0, int_enable});
    wr(A_FLAG, 32'h0000_3500);
    rd(A_FLAG, 32'h0000_0501, "flag set-only read");
    chk("list valid", 32'h1, {31'h0, list_valid});
    chk("fetch req", 32'h1, {31'h0, fetch_req});
    ev(1, 16'h0000);
    chk("fetch req after ack", 32'h0, {31'h0, fetch_req});
    // response event, interrupt, clear by writing one
    wr(A_MSK, 32'h0000_0001);
    ev(0, 16'h0000);
    chk("irq on response", 32'h1, {31'h0, irq});
    rd(A_FLAG, 32'h0000_4501, "responses_available set");
    wr(A_FLAG, 32'h0000_4100);
    rd(A_FLAG, 32'h0000_0501, "responses_available cleared");
    wr(A_STS, 32'h0000_0007);
    chk("irq after clear", 32'h0, {31'h0, irq});
    ev(2, 16'h0000);
    chk("list valid after end", 32'h0, {31'h0, list_valid});
    // host rebuilds the list and marks it valid again
    wr(A_FLAG, 32'h0000_1100);
    chk("list valid again", 32'h1, {31'h0, list_valid});
    // every stop reason
    for (int r = 0; r < 4; r++)
    begin
      wr(A_FLAG, 32'h0000_0500);
      wr(A_ADRH, 32'h0000_002A);
      ev(3, 16'(r));
      chk("running after stop", 32'h0, {31'h0, running});
      rd(A_ADRL, {16'h0000, stop_code[r]}, "stop code");
      rd(A_ADRH, 32'h0000_0000, "high after stop");
    end
    rd(A_STS, 32'h0000_0002, "stop status");
    rd(A_MSK, 32'h0000_0001, "mask readback");
    // reset with abort skips self-test
    wr(A_FLAG, 32'h0000_8200);
    chk("skip flag", 32'h1, {31'h0, init_skip});
    chk("init start pulse", 32'h1, {31'h0, init_start});
    chk("int enable after reset", 32'h0, {31'h0, int_enable});
    rd(A_FLAG, 32'h0000_0201, "flag in reset");
    ev(4, 16'h0000);
    rd(A_ADRL, {16'h0000, CODE_SKIP}, "skip code");
    rd(A_STS, 32'h0000_0006, "init done status");
    // plain reset then failing self-test
    wr(A_FLAG, 32'h0000_0200);
    chk("skip flag clear", 32'h0, {31'h0, init_skip});
    ev(5, 16'h1234);
    rd(A_ADRL, {16'h0000, CODE_FAIL}, "fail code");
    rd(A_ADRH, 32'h0000_1234, "fail detail");
    final_report();
  end
endmodule
